//--- sms_params.svh
// Register map, field positions, reset values and timing counts of the serial port.
`ifndef SMS_PARAMS_SVH
`define SMS_PARAMS_SVH

// ==========================================================================
// Register offsets
`define SMS_ADDR_STATUS  16'h4320
`define SMS_ADDR_TXD     16'h4322
`define SMS_ADDR_RXD     16'h4324
`define SMS_ADDR_CTL     16'h4326

// ==========================================================================
// Control fields
`define SMS_CTL_EN       0
`define SMS_CTL_MASTER   1
`define SMS_CTL_CLOCK_POLARITY_SELECT     2
`define SMS_CTL_CLOCK_PHASE_SELECT     3
`define SMS_CTL_TIE      4
`define SMS_CTL_RIE      5
`define SMS_CTL_LSB      8
`define SMS_CTL_CLKSRC   9
`define SMS_CTL_WMASK    16'h033f
`define SMS_CTL_RESET    16'h0000

// ==========================================================================
// Status fields and data resets
`define SMS_ST_TXE       0
`define SMS_ST_RXF       1
`define SMS_ST_BUSY      2
`define SMS_TXD_RESET    8'h00
`define SMS_RXD_RESET    8'h00
`define SMS_RD_ZERO      16'h0000

// ==========================================================================
// Timing: serial clock from the peripheral clock divided by four, 16 edges a byte.
`define SMS_PCLK_DIV     4
`define SMS_LAST_EDGE    4'hf
`define SMS_FIRST_EDGE   4'h0

`endif

//--- sms_peer.sv
// Far-side serial device: answers the port as a slave or drives it as a master.
module sms_peer (
  // Pacing clock
  input  wire logic ref_clk,
  // Serial wires
  input  wire logic sclk,
  input  wire logic din,
  output logic      dout,
  output logic      sclk_drv,
  output logic      sel_n
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] tx_b;
  logic [7:0] rx_b;
  logic       pol;
  logic       pha;
  logic       lsb;
  logic       as_master;
  int         idx;
  int         edges;

  initial begin
    dout      = 1'b0;
    sclk_drv  = 1'b0;
    sel_n     = 1'b1;
    as_master = 1'b0;
    edges     = 16;
  end

  // ==========
  // Slave side. Outside a frame the data line toggles, so stale bits never pass as good ones.
  task automatic load(input logic [7:0] b, input logic p, input logic h, input logic l);
    tx_b  = b;
    pol   = p;
    pha   = h;
    lsb   = l;
    edges = 0;
    idx   = h ? -1 : 0;
    dout  = h ? ~dout : (l ? b[0] : b[7]);
  endtask

  always @(sclk) begin
    if (!as_master && edges < 16) begin
      edges++;
      if ((sclk != pol) ^ pha) begin
        rx_b = lsb ? {din, rx_b[7:1]} : {rx_b[6:0], din};
      end else begin
        idx++;
        dout = (idx < 8) ? (lsb ? tx_b[idx] : tx_b[7 - idx]) : ~dout;
      end
    end
  end

  // ==========
  // Master side, clock idle low, sample on the rising edge; half period of six cycles.
  task automatic mxfer(input logic [7:0] b);
    as_master = 1'b1;
    sel_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    for (int i = 7; i >= 0; i--) begin
      dout <= b[i];
      repeat (6) @(posedge ref_clk);
      sclk_drv <= 1'b1;
      rx_b = {rx_b[6:0], din};
      repeat (6) @(posedge ref_clk);
      sclk_drv <= 1'b0;
    end
    repeat (6) @(posedge ref_clk);
    sel_n <= 1'b1;
    dout  <= ~dout;
    repeat (4) @(posedge ref_clk);
    as_master = 1'b0;
  endtask
endmodule

//--- sms_pkg.sv
// Types shared by the serial port modules.
package sms_pkg;

  typedef enum logic [0:0] {
    SMS_IDLE  = 1'b0,
    SMS_SHIFT = 1'b1
  } sms_state_t;

  typedef struct packed {
    logic [1:0] sync;
    logic       last;
    logic [7:0] cnt;
    logic       tick;
  } sms_tick_st_t;

  typedef struct packed {
    logic [15:0] ctl;
    logic [7:0]  tx_buf;
    logic        tx_empty;
    logic [7:0]  rx_buf;
    logic        rx_full;
    logic [7:0]  tx_sr;
    logic [7:0]  rx_sr;
    logic [3:0]  half;
    logic        loaded;
    sms_state_t  state;
    logic        busy;
    logic        sdo;
    logic        sclk;
    logic        sclk_oe;
    logic [1:0]  ss_sync;
    logic [1:0]  sck_sync;
    logic        sck_last;
    logic [1:0]  sdi_sync;
    logic        irq;
    logic [15:0] rdata;
  } sms_port_st_t;

endpackage

//--- sms_port.sv
// Byte-wide synchronous serial port, master or slave, with its register file.
//
// The strobed register port was chosen for this implementation.
`include "sms_params.svh"

// Behaviour
// (R1) Master: busy rises at transfer start, holds during it, falls when done.
// (R2) Slave: busy bit shows select input, 1 while select is low.
// (R3) Receive-full sets on byte moved to buffer, clears on receive register read.
// (R4) Transmit-empty clears on transmit write, sets at load into shifter; resets 1.
// (R5) Master: transmit write starts transfer and clock; next byte may be queued.
// (R6) Slave: loaded byte shifts only on external clock edges.
// (R7) Transmit-empty interrupt pulses with the flag set when its enable is 1.
// (R8) Receive-full interrupt pulses when a byte reaches buffer if enabled.
// (R9) A new byte overwrites an unread receive buffer silently.
// (R10) Bit-order select: 1 LSB first, 0 MSB first; resets 0.
// (R11) Serial output drives high for 1, low for 0.
// (R12) Input bits are assembled into a byte and loaded into receive buffer.
// (R13) Clock source: 1 timer channel 1, 0 peripheral clock over four; resets 0.
// (R14) Polarity select: 1 clock active low, 0 active high; resets 0.
// (R15) Phase select with polarity picks the drive edge and the sample edge.
// (R16) Role select: 1 master drives clock, 0 slave takes external clock.
// (R17) Enable bit 1 runs the port, 0 stops it; resets 0.
// (R18) Software clears enable before changing phase, polarity or role.
// (R19) Software sets enable before writing transmit data.
// (R20) Software leaves control alone while busy or receive-full reads 1.
// (R21) Transmit-empty interrupt exists only in master role.
// (R22) Receive buffer loads only after exactly eight bits shifted in.
// (R23) Both causes share one interrupt line; status flags tell them apart.
// (R24) Reserved bits read 0 and ignore writes.
module sms_port #(
  parameter int CLK_DIV = `SMS_PCLK_DIV
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Serial pins and timer channel 1 clock
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  output logic             sdo,
  input  wire logic        sdi,
  input  wire logic        slave_select_n,
  input  wire logic        timer_ch1_clk,
  // Request to the interrupt controller
  output logic             irq_req
);

  sms_pkg::sms_port_st_t s_q;
  sms_pkg::sms_port_st_t s_d;

  logic tick;
  logic en;
  logic master;
  logic clock_polarity_select;
  logic clock_phase_select;
  logic lsb;
  logic sel;
  logic start;
  logic edge_ev;
  logic tx_ev;
  logic rx_ev;
  logic samp;
  logic [7:0] rx_next;

  // ==========================================================================
  // Shift helpers
  function automatic logic out_bit(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? v[0] : v[7];
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] v, input logic lsb_first);
    return lsb_first ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic lsb_first);
    return lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // Read decode; reserved bits and unmapped offsets return zero.
  function automatic logic [15:0] rd_value(input logic [15:0] a, input sms_pkg::sms_port_st_t st,
                                           input logic busy_bit);
    logic [15:0] v;
    v = `SMS_RD_ZERO;
    unique case (a)
      `SMS_ADDR_STATUS: begin
        v[`SMS_ST_TXE]  = st.tx_empty;
        v[`SMS_ST_RXF]  = st.rx_full;
        v[`SMS_ST_BUSY] = busy_bit;
      end
      `SMS_ADDR_TXD: v[7:0] = st.tx_buf;
      `SMS_ADDR_RXD: v[7:0] = st.rx_buf;
      `SMS_ADDR_CTL: v      = st.ctl;
      default:       v      = `SMS_RD_ZERO;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Serial clock source
  sms_tick_gen #(
    .DIV (CLK_DIV)
  ) u_tick (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .clk_src_sel  (s_q.ctl[`SMS_CTL_CLKSRC]),
    .timer_clk_in (timer_ch1_clk),
    .tick         (tick)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    s_d          = s_q;
    s_d.irq      = 1'b0;
    s_d.ss_sync  = {s_q.ss_sync[0], slave_select_n};
    s_d.sck_sync = {s_q.sck_sync[0], sclk_in};
    s_d.sck_last = s_q.sck_sync[1];
    s_d.sdi_sync = {s_q.sdi_sync[0], sdi};
    en      = s_q.ctl[`SMS_CTL_EN];
    master  = s_q.ctl[`SMS_CTL_MASTER];
    clock_polarity_select    = s_q.ctl[`SMS_CTL_CLOCK_POLARITY_SELECT];
    clock_phase_select    = s_q.ctl[`SMS_CTL_CLOCK_PHASE_SELECT];
    lsb     = s_q.ctl[`SMS_CTL_LSB];
    sel     = ~s_q.ss_sync[1];
    tx_ev   = 1'b0;
    rx_ev   = 1'b0;
    samp    = 1'b0;
    rx_next = s_q.rx_sr;
    start   = 1'b0;
    // Master counts its own ticks; slave counts each edge of the synchronised pin clock.
    edge_ev = master ? (s_q.state == sms_pkg::SMS_SHIFT && tick)                       // R16
                     : (sel && (s_q.sck_sync[1] ^ s_q.sck_last));                      // R6
    s_d.sclk_oe = en & master;  // R16

    if (!en) begin
      // Stopping mid-byte drops the byte; the clock parks at its idle level.
      s_d.state  = sms_pkg::SMS_IDLE;  // R17
      s_d.half   = `SMS_FIRST_EDGE;
      s_d.loaded = 1'b0;
      s_d.busy   = 1'b0;
      s_d.sclk   = clock_polarity_select;  // R14
    end else if (!master && !sel) begin
      s_d.half   = `SMS_FIRST_EDGE;
      s_d.loaded = 1'b0;
      s_d.state  = sms_pkg::SMS_IDLE;
    end else begin
      // The idle clock tracks polarity, so the pin is right when its driver turns on.
      if (s_q.state == sms_pkg::SMS_IDLE) begin
        s_d.sclk = clock_polarity_select;  // R14
      end
      start = master ? (s_q.state == sms_pkg::SMS_IDLE && !s_q.tx_empty)  // R5
                     : !s_q.loaded;                                         // R6
      if (start) begin
        s_d.tx_sr  = s_q.tx_buf;
        s_d.loaded = 1'b1;
        s_d.state  = sms_pkg::SMS_SHIFT;
        s_d.busy   = master;  // R1
        s_d.half   = `SMS_FIRST_EDGE;
        s_d.sclk   = clock_polarity_select;  // R14
        if (!s_q.tx_empty) begin
          s_d.tx_empty = 1'b1;  // R4
          tx_ev        = master;  // R21
        end
        if (!clock_phase_select) begin
          // Phase 0 puts the first bit out before the first edge.
          s_d.sdo   = out_bit(s_q.tx_buf, lsb);  // R15 R11 R10
          s_d.tx_sr = shift_out(s_q.tx_buf, lsb);
        end
      end else if (edge_ev) begin
        if (master) begin
          s_d.sclk = ~s_q.sclk;  // R5
        end
        // Even counts are leading edges; phase decides whether they sample or drive.
        samp = ~s_q.half[0] ^ clock_phase_select;  // R15
        if (samp) begin
          rx_next    = shift_in(s_q.rx_sr, s_q.sdi_sync[1], lsb);  // R12 R10
          s_d.rx_sr  = rx_next;
        end else if (!(clock_phase_select == 1'b0 && s_q.half == `SMS_LAST_EDGE)) begin
          s_d.sdo   = out_bit(s_q.tx_sr, lsb);  // R11 R10
          s_d.tx_sr = shift_out(s_q.tx_sr, lsb);
        end
        if (s_q.half == `SMS_LAST_EDGE) begin
          s_d.rx_buf = rx_next;  // R22 R9 R12
          rx_ev      = 1'b1;
          s_d.half   = `SMS_FIRST_EDGE;
          s_d.loaded = 1'b0;
          s_d.state  = sms_pkg::SMS_IDLE;
          s_d.busy   = 1'b0;  // R1
        end else begin
          s_d.half = s_q.half + 4'h1;
        end
      end
    end

    // ------------------------------------------------------------------------
    // Register writes; a write in the load cycle queues the next byte.
    if (reg_wr) begin
      if (reg_addr == `SMS_ADDR_TXD) begin
        s_d.tx_buf   = reg_wdata[7:0];  // R24
        s_d.tx_empty = 1'b0;  // R4
      end else if (reg_addr == `SMS_ADDR_CTL) begin
        s_d.ctl = reg_wdata & `SMS_CTL_WMASK;  // R24
      end
    end

    // Reads answer the cycle after the strobe and are zero otherwise.
    s_d.rdata = reg_rd ? rd_value(reg_addr, s_q, master ? s_q.busy : sel) : `SMS_RD_ZERO;  // R2 R24
    if (reg_rd && reg_addr == `SMS_ADDR_RXD) begin
      s_d.rx_full = 1'b0;  // R3
    end
    // A byte completing in the read cycle keeps the flag set.
    if (rx_ev) begin
      s_d.rx_full = 1'b1;  // R3 R9
    end

    // Both causes share one pulse; software reads the flags to tell them apart.
    s_d.irq = (tx_ev & s_q.ctl[`SMS_CTL_TIE]) | (rx_ev & s_q.ctl[`SMS_CTL_RIE]);  // R7 R8 R23
  end

  // ==========================================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q          <= '0;
      s_q.ctl      <= `SMS_CTL_RESET;  // R10 R13 R14 R15 R17
      s_q.tx_buf   <= `SMS_TXD_RESET;
      s_q.rx_buf   <= `SMS_RXD_RESET;
      s_q.tx_empty <= 1'b1;  // R4
      s_q.ss_sync  <= 2'h3;
      s_q.sck_sync <= 2'h0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign sclk_out  = s_q.sclk;
  assign sclk_oe   = s_q.sclk_oe;
  assign sdo       = s_q.sdo;
  assign irq_req   = s_q.irq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence load_seq;
    start && en ##1 s_q.loaded && s_q.half == `SMS_FIRST_EDGE;
  endsequence

  sequence master_start_seq;
    master && start && en && !(reg_wr && reg_addr == `SMS_ADDR_CTL);
  endsequence

  sequence shift_begin_seq;
    s_q.busy && s_q.loaded && s_q.state == sms_pkg::SMS_SHIFT;
  endsequence

  busy_during_shift_a: assert property (master_start_seq |=> shift_begin_seq)  // R1
    else $error("busy not raised at master start");

  busy_hold_a: assert property (en && master && s_q.state == sms_pkg::SMS_SHIFT |-> s_q.busy)  // R1
    else $error("busy low during master shift");

  slave_select_a: assert property (reg_rd && reg_addr == `SMS_ADDR_STATUS && !master
                                   |=> reg_rdata[`SMS_ST_BUSY] == !$past(s_q.ss_sync[1]))  // R2
    else $error("slave busy bit does not follow select");

  rx_full_set_a: assert property (rx_ev |=> s_q.rx_full && s_q.rx_buf == $past(rx_next))  // R3
    else $error("receive byte not held with full flag");

  rx_full_clr_a: assert property (reg_rd && reg_addr == `SMS_ADDR_RXD && !rx_ev |=> !s_q.rx_full)  // R3
    else $error("receive-full not cleared by read");

  tx_empty_clr_a: assert property (reg_wr && reg_addr == `SMS_ADDR_TXD |=> !s_q.tx_empty)  // R4
    else $error("transmit-empty not cleared by write");

  tx_load_a: assert property (load_seq |-> master ? s_q.tx_empty || $past(reg_wr) : 1'b1)  // R4
    else $error("transmit-empty not set at load");

  irq_cause_a: assert property (irq_req |-> $past(tx_ev && s_q.ctl[`SMS_CTL_TIE] && master)
                                || $past(rx_ev && s_q.ctl[`SMS_CTL_RIE]))  // R7
    else $error("interrupt without enabled cause");

  irq_rx_a: assert property (rx_ev && s_q.ctl[`SMS_CTL_RIE] |=> irq_req)  // R8
    else $error("receive interrupt missing");

  byte_len_a: assert property (rx_ev |-> s_q.half == `SMS_LAST_EDGE && edge_ev)  // R22
    else $error("byte completed before sixteen edges");

  disable_stop_a: assert property (!en |=> !s_q.busy && !s_q.loaded && s_q.sclk == $past(clock_polarity_select))  // R17
    else $error("port still running while disabled");

  clock_drive_a: assert property (sclk_oe |-> $past(en && master))  // R16
    else $error("clock driven outside master role");

  reserved_zero_a: assert property (reg_rdata[15:10] == 6'h00)  // R24
    else $error("reserved read bits not zero");

  irq_tx_a: assert property (tx_ev && s_q.ctl[`SMS_CTL_TIE] |=> irq_req)  // R7
    else $error("transmit interrupt missing");

  tx_irq_slave_a: assert property (!master  // R21
                                   |=> !irq_req || $past(rx_ev && s_q.ctl[`SMS_CTL_RIE]))
    else $error("transmit interrupt raised in slave role");

  sclk_idle_a: assert property (sclk_oe && s_q.state == sms_pkg::SMS_IDLE |-> sclk_out == $past(clock_polarity_select))  // R14
    else $error("driven clock not at its idle level");

  sequence phase0_start_seq;
    start && !clock_phase_select;
  endsequence

  first_bit_a: assert property (phase0_start_seq |=> sdo == $past(lsb ? s_q.tx_buf[0] : s_q.tx_buf[7]))  // R15 R11
    else $error("first bit not presented at load");

  busy_fall_a: assert property (master && rx_ev |=> !s_q.busy)  // R1
    else $error("busy still high after transfer end");

  master_busy_read_a: assert property (reg_rd && reg_addr == `SMS_ADDR_STATUS && master  // R1
                                       |=> reg_rdata[`SMS_ST_BUSY] == $past(s_q.busy))
    else $error("master busy bit does not follow transfer");

  rx_full_hold_a: assert property (s_q.rx_full && !(reg_rd && reg_addr == `SMS_ADDR_RXD) |=> s_q.rx_full)  // R3
    else $error("receive-full dropped without a read");

  tx_full_hold_a: assert property (!s_q.tx_empty && !start |=> !s_q.tx_empty)  // R4
    else $error("transmit-empty set without a load");

  deselect_reset_a: assert property (en && !master && !sel |=> !s_q.loaded && s_q.half == `SMS_FIRST_EDGE)  // R6
    else $error("deselected slave kept its bit count");

  sdo_hold_a: assert property (en && master && s_q.state == sms_pkg::SMS_SHIFT && !edge_ev  // R11
                               |=> $stable(sdo))
    else $error("serial output moved between clock edges");

  rx_buf_hold_a: assert property (!rx_ev |=> $stable(s_q.rx_buf))  // R22
    else $error("receive buffer changed without a full byte");

  ctl_write_a: assert property (reg_wr && reg_addr == `SMS_ADDR_CTL  // R24
                                |=> s_q.ctl == ($past(reg_wdata) & `SMS_CTL_WMASK))
    else $error("control write not stored through its mask");

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == `SMS_RD_ZERO)  // R24
    else $error("read data not zero outside a read");

endmodule

//--- sms_tick_gen.sv
// Half-period tick source for the serial clock in master role.
`include "sms_params.svh"

module sms_tick_gen #(
  parameter int DIV = `SMS_PCLK_DIV
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // Source select and timer channel input
  input  wire logic clk_src_sel,
  input  wire logic timer_clk_in,
  // Tick out, one cycle per serial clock edge
  output logic      tick
);

  localparam logic [7:0] HALF_M1 = 8'(DIV / 2 - 1);

  sms_pkg::sms_tick_st_t s_q;
  sms_pkg::sms_tick_st_t s_d;

  // ==========================================================================
  // Next state
  always_comb begin
    s_d      = s_q;
    s_d.sync = {s_q.sync[0], timer_clk_in};
    s_d.last = s_q.sync[1];
    s_d.tick = 1'b0;
    if (clk_src_sel) begin
      // Each edge of the timer output is one half period of the serial clock.
      s_d.tick = s_q.sync[1] ^ s_q.last;  // R13
      s_d.cnt  = '0;
    end else if (s_q.cnt == HALF_M1) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;  // R13
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

//--- testbench.sv
// Self-checking bench for the serial port: register file, slave and master transfers.
`include "sms_params.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] a_st = `SMS_ADDR_STATUS;
  localparam logic [15:0] a_tx = `SMS_ADDR_TXD;
  localparam logic [15:0] a_rx = `SMS_ADDR_RXD;
  localparam logic [15:0] a_ct = `SMS_ADDR_CTL;

  logic        ref_clk;
  logic        rstn;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        sclk_out;
  logic        sclk_oe;
  logic        sclk_drv;
  logic        sclk_w;
  logic        sdo;
  logic        sdi;
  logic        sel_n;
  logic        timer_clk;
  logic        irq_req;
  int          err_total = 0;
  int          checks = 0;
  int          irq_n = 0;

  assign sclk_w = sclk_oe ? sclk_out : sclk_drv;

  // Divider doubled so the input synchronisers settle well before each sample edge.
  sms_port #(.CLK_DIV(8)) i_sms_port (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(sclk_w), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
    .sdo(sdo), .sdi(sdi), .slave_select_n(sel_n), .timer_ch1_clk(timer_clk), .irq_req(irq_req)
  );
  sms_peer i_sms_peer (
    .ref_clk(ref_clk), .sclk(sclk_w), .din(sdo), .dout(sdi), .sclk_drv(sclk_drv), .sel_n(sel_n)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    timer_clk = 1'b0;
    forever begin
      repeat (5) @(posedge ref_clk);
      timer_clk <= ~timer_clk;
    end
  end

  always @(posedge ref_clk) begin
    if (irq_req === 1'b1) begin
      irq_n++;
    end
  end

  // ==========
  // Checks and bus cycles
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    checks++;
    if (got != exp) begin
      err_total++;
      $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    if (err_total == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // One idle cycle, so a following write never reassigns the strobe in the same time step.
    @(posedge ref_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    chk16(d, e);
  endtask

  task automatic wait_idle(output logic [15:0] d);
    int n;
    n = 0;
    d = 16'hffff;
    while (d[2] !== 1'b0 && n < 300) begin
      rd(a_st, d);
      n++;
    end
    if (d[2] !== 1'b0) begin
      err_total++;
      $display("[ERR] %0t busy never fell", $time);
      finish_test();
    end
  endtask

  // ==========
  // Scenarios
  task automatic t_reset;
    rd_chk(a_st, 16'h0001);
    rd_chk(a_ct, 16'h0000);
    rd_chk(a_tx, 16'h0000);
    rd_chk(a_rx, 16'h0000);
    rd_chk(16'h4328, 16'h0000);
  endtask

  task automatic t_reserved;
    wr(a_ct, 16'hfffe);
    rd_chk(a_ct, 16'h033e);
    wr(a_ct, 16'h0002);
    wr(a_rx, 16'h1234);
    wr(a_st, 16'hffff);
    wr(16'h4328, 16'hffff);
    wr(a_tx, 16'h5aa5);
    repeat (20) @(posedge ref_clk);
    rd_chk(a_tx, 16'h00a5);
    rd_chk(a_rx, 16'h0000);
    rd_chk(a_st, 16'h0000);
  endtask

  task automatic t_slave;
    int base;
    wr(a_ct, 16'h0030);
    wr(a_ct, 16'h0031);
    base = irq_n;
    fork
      i_sms_peer.mxfer(8'h3c);
      begin
        repeat (30) @(posedge ref_clk);
        rd_chk(a_st, 16'h0005);
      end
    join
    rd_chk(a_st, 16'h0003);
    chk16({8'h00, i_sms_peer.rx_b}, 16'h00a5);
    rd_chk(a_rx, 16'h003c);
    i_sms_peer.mxfer(8'h11);
    i_sms_peer.mxfer(8'h22);
    rd_chk(a_rx, 16'h0022);
    rd_chk(a_st, 16'h0001);
    chkn(irq_n - base, 3);
  endtask

  task automatic mx(input logic [15:0] ctl, input logic [7:0] tx, input logic [7:0] ptx, input int nirq);
    logic [15:0] d;
    int          base;
    wr(a_ct, 16'h0000);
    wr(a_ct, ctl & 16'hfffe);
    wr(a_ct, ctl);
    repeat (2) @(posedge ref_clk);
    i_sms_peer.load(ptx, ctl[2], ctl[3], ctl[8]);
    base = irq_n;
    wr(a_tx, {8'h00, tx});
    repeat (8) @(posedge ref_clk);
    rd_chk(a_st, 16'h0005);
    wait_idle(d);
    chk16(d, 16'h0003);
    rd_chk(a_rx, {8'h00, ptx});
    rd_chk(a_st, 16'h0001);
    chk16({8'h00, i_sms_peer.rx_b}, {8'h00, tx});
    chkn(irq_n - base, nirq);
  endtask

  task automatic t_master;
    mx(16'h0033, 8'ha5, 8'h3c, 2);
    mx(16'h010f, 8'h96, 8'hc1, 0);
    mx(16'h021b, 8'h5a, 8'h0f, 1);
    mx(16'h0127, 8'h81, 8'h7e, 1);
  endtask

  initial begin
    rstn      = 1'b0;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_reserved();
    t_slave();
    t_master();
    // A second reset after traffic must bring every register back to its reset value.
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    finish_test();
  end
endmodule
